// file: tcfd_pkg.sv
/*
 * Timer unit constants: offsets, fields, resets, edge codes.
 * Assumes byte offsets on a word-wide register port.
 */
package tcfd_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_UNIT_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PRESCALE    = 8'h04;
    localparam logic [7:0] OFF_START_TRIG  = 8'h08;
    localparam logic [7:0] OFF_STOP_TRIG   = 8'h0c;
    localparam logic [7:0] OFF_ENABLE_STAT = 8'h10;
    localparam logic [7:0] OFF_TIMER_OUT   = 8'h14;
    localparam logic [7:0] OFF_OUT_ENABLE  = 8'h18;
    localparam logic [7:0] OFF_OUT_MODE    = 8'h1c;
    localparam logic [7:0] OFF_OUT_LEVEL   = 8'h20;
    localparam logic [7:0] OFF_FILTER_EN   = 8'h24;
    localparam logic [7:0] OFF_CH_BASE     = 8'h40;
    localparam logic [7:0] OFF_CH_STRIDE   = 8'h10;
    localparam logic [7:0] OFF_CH_MODE     = 8'h00;
    localparam logic [7:0] OFF_CH_DATA     = 8'h04;
    localparam logic [7:0] OFF_CH_COUNT    = 8'h08;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int POS_POWER_EN     = 0;
    localparam int POS_START_IRQ    = 0;
    localparam int POS_EDGE_LO      = 6;
    localparam int POS_CLK_SEL      = 15;
    localparam int POS_PRESCALE_B   = 4;

    // ************************************************************
    // Reset values and divider channel mask
    // ************************************************************
    localparam logic [15:0] RST_MODE     = 16'h0000;
    localparam logic [15:0] RST_DATA     = 16'h0000;
    localparam logic [15:0] RST_COUNT    = 16'hffff;
    localparam logic [7:0]  RST_PRESCALE = 8'h00;
    localparam logic [3:0]  DIV_CH_MASK  = 4'h9;

    // ************************************************************
    // Edge select encodings
    // ************************************************************
    typedef enum logic [1:0] {
        TCFD_EDGE_FALL = 2'b00,
        TCFD_EDGE_RISE = 2'b01,
        TCFD_EDGE_BOTH = 2'b10,
        TCFD_EDGE_RSVD = 2'b11
    } tcfd_edge_type;

endpackage : tcfd_pkg

// file: tcfd_edge_detect.sv
/*
 * Pin synchroniser, noise filter and edge detector.
 * Assumes an async pin and a one-cycle sample_en_in pulse.
 */
`timescale 1ns/1ns
module tcfd_edge_detect (
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       clear_in,
    input  wire logic       sample_en_in,
    input  wire logic       pin_in,
    input  wire logic       filter_en_in,
    input  wire logic [1:0] edge_sel_in,
    output logic            edge_out
);

    // ************************************************************
    // Synchroniser and sampled level
    // ************************************************************
    logic sync1_q;
    logic sync2_q;
    logic samp_q;
    logic lvl_q;
    logic lvl_d;
    logic rise_w;
    logic fall_w;
    logic hit_w;

    // Filter waits for two equal samples
    assign lvl_d  = (!filter_en_in || samp_q == sync2_q) ? sync2_q : lvl_q;
    assign rise_w = !lvl_q && lvl_d;
    assign fall_w = lvl_q && !lvl_d;
    assign hit_w  =
        (edge_sel_in == tcfd_pkg::TCFD_EDGE_RISE) ? rise_w :
        (edge_sel_in == tcfd_pkg::TCFD_EDGE_BOTH) ? (rise_w || fall_w) :
        (edge_sel_in == tcfd_pkg::TCFD_EDGE_FALL) ? fall_w : 1'b0;

    always_ff @(posedge mclk_in) begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
    end

    // see [RULE23]
    always_ff @(posedge mclk_in) begin
        if (rst_in || clear_in) begin
            samp_q   <= 1'b0;
            lvl_q    <= 1'b0;
            edge_out <= 1'b0;
        end else begin
            edge_out <= sample_en_in && hit_w;
            if (sample_en_in) begin
                samp_q <= sync2_q;
                lvl_q  <= lvl_d;
            end
        end
    end

endmodule : tcfd_edge_detect

// file: tcfd_timer_unit.sv
/*
 * Four-channel timer unit; channels 0 and 3 divide their input pins.
 * Registers on a plain port, read data one cycle late.
 * Pins are asynchronous inputs.
 */
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns

// Operation
// [RULE1] Power bit off: clock stopped, access refused
// [RULE2] Power off returns all registers to reset
// [RULE3] Start trigger sets enable, reads zero
// [RULE4] Start loads data into counter next clock
// [RULE5] Start load irq/toggle only if selected
// [RULE6] Count down, reload at zero, continue
// [RULE7] Zero count raises interrupt, toggles output
// [RULE8] Data writable, counter readable any time
// [RULE9] Software keeps mode bits fixed while running
// [RULE10] Stop trigger clears enable, counter holds
// [RULE11] Stopping keeps present output level
// [RULE12] Output enable off: software level drives pin
// [RULE13] Stopped channel never toggles output
// [RULE14] Software sets output enable before restart
// [RULE15] Software parks port latch before power-off
// [RULE16] Master output mode ignores level bit
// [RULE17] Software selects master output mode
// [RULE18] Software configures prescaler, filter, mode, data
// [RULE19] Divider exists only on channels 0, 3
// [RULE20] Counting steps on valid input pin edges
// [RULE21] Single edge: out = in / 2(data+1)
// [RULE22] New data value used next period
// [RULE23] Edges sampled on operating clock, pulse irq
module tcfd_timer_unit #(
    parameter int         CH_NUM   = 4,
    parameter logic [3:0] DIV_MASK = tcfd_pkg::DIV_CH_MASK
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [3:0]  timer_input_pin_in,
    output logic      [31:0] rdata_out,
    output logic      [3:0]  timer_output_out,
    output logic      [3:0]  channel_interrupt_out
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    function automatic logic [15:0] tcfd_scale_mask(input logic [3:0] n);
        tcfd_scale_mask = 16'(17'h00001 << n) - 16'h0001;
    endfunction : tcfd_scale_mask

    function automatic logic [7:0] tcfd_ch_addr(input int ch,
                                                input logic [7:0] off);
        tcfd_ch_addr = tcfd_pkg::OFF_CH_BASE
                     + 8'(ch * 16) + off;
    endfunction : tcfd_ch_addr

    // ************************************************************
    // Unit power and prescaler
    // ************************************************************
    logic        power_q;
    logic [7:0]  prescale_q;
    logic [15:0] pre_cnt_q;
    logic        unit_clr_w;
    logic        wr_ok_w;
    logic        rd_ok_w;
    logic        tick_a_w;
    logic        tick_b_w;
    logic [15:0] mask_a_w;
    logic [15:0] mask_b_w;

    assign unit_clr_w = !power_q; // see [RULE2]
    // Off: only power reg answers  see [RULE1]
    assign wr_ok_w  = wr_in && power_q;
    assign rd_ok_w  = rd_in && power_q;
    assign mask_a_w = tcfd_scale_mask(prescale_q[3:0]);
    assign mask_b_w = tcfd_scale_mask(
        prescale_q[tcfd_pkg::POS_PRESCALE_B +: 4]);
    // see [RULE1]
    assign tick_a_w = power_q && ((pre_cnt_q & mask_a_w) == mask_a_w);
    assign tick_b_w = power_q && ((pre_cnt_q & mask_b_w) == mask_b_w);

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            power_q <= 1'b0;
        end else if (wr_in && addr_in == tcfd_pkg::OFF_UNIT_CTRL) begin
            power_q <= wdata_in[tcfd_pkg::POS_POWER_EN]; // see [RULE1]
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || unit_clr_w) begin
            prescale_q <= tcfd_pkg::RST_PRESCALE; // see [RULE2]
            pre_cnt_q  <= 16'h0000;
        end else begin
            pre_cnt_q <= pre_cnt_q + 16'h0001;
            if (wr_ok_w && addr_in == tcfd_pkg::OFF_PRESCALE) begin
                prescale_q <= wdata_in[7:0];
            end
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    logic [3:0]  en_vec_w;
    logic [3:0]  to_vec_w;
    logic [3:0]  toe_vec_w;
    logic [3:0]  tom_vec_w;
    logic [3:0]  tol_vec_w;
    logic [3:0]  nfe_vec_w;
    logic [15:0] ch_rd_w [CH_NUM];
    logic [CH_NUM-1:0] ch_hit_w;

    genvar g;
    generate
        for (g = 0; g < CH_NUM; g++) begin : g_ch
            localparam logic [7:0] A_MODE =
                tcfd_ch_addr(g, tcfd_pkg::OFF_CH_MODE);
            localparam logic [7:0] A_DATA =
                tcfd_ch_addr(g, tcfd_pkg::OFF_CH_DATA);
            localparam logic [7:0] A_CNT =
                tcfd_ch_addr(g, tcfd_pkg::OFF_CH_COUNT);
            if (DIV_MASK[g]) begin : g_div // see [RULE19]
                logic [15:0] mode_q;
                logic [15:0] data_q;
                logic [15:0] cnt_q;
                logic        en_q;
                logic        pend_q;
                logic        to_q;
                logic        toe_q;
                logic        tom_q;
                logic        tol_q;
                logic        nfe_q;
                logic        pin_q;
                logic        irq_q;
                logic        edge_w;
                logic        tick_w;
                logic        start_w;
                logic        stop_w;
                logic        zero_w;
                logic        event_w;
                logic        toggle_w;
                logic        wr_to_w;
                logic        to_d;

                assign tick_w  = mode_q[tcfd_pkg::POS_CLK_SEL] ?
                                 tick_b_w : tick_a_w;
                assign start_w = wr_ok_w && wdata_in[g] &&
                                 addr_in == tcfd_pkg::OFF_START_TRIG;
                assign stop_w  = wr_ok_w && wdata_in[g] &&
                                 addr_in == tcfd_pkg::OFF_STOP_TRIG;
                assign zero_w  = cnt_q == 16'h0000;
                // Start load or zero
                // when chosen  see [RULE5] see [RULE7]
                assign event_w = en_q && edge_w && (pend_q ?
                    mode_q[tcfd_pkg::POS_START_IRQ] : zero_w);
                // see [RULE13]
                assign toggle_w = event_w && toe_q;
                // Write ignored while output enabled
                assign wr_to_w = wr_ok_w && !toe_q &&
                                 addr_in == tcfd_pkg::OFF_TIMER_OUT;
                assign to_d = toggle_w ? !to_q :
                              wr_to_w ? wdata_in[g] : to_q; // see [RULE12]

                tcfd_edge_detect u_edge (
                    .mclk_in      (mclk_in),
                    .rst_in       (rst_in),
                    .clear_in     (unit_clr_w || !en_q),
                    .sample_en_in (tick_w),
                    .pin_in       (timer_input_pin_in[g]),
                    .filter_en_in (nfe_q),
                    .edge_sel_in  (mode_q[tcfd_pkg::POS_EDGE_LO +: 2]),
                    .edge_out     (edge_w)
                ); // see [RULE20] see [RULE23]

                always_ff @(posedge mclk_in) begin
                    if (rst_in || unit_clr_w) begin // see [RULE2]
                        mode_q <= tcfd_pkg::RST_MODE;
                        data_q <= tcfd_pkg::RST_DATA;
                        toe_q  <= 1'b0;
                        tom_q  <= 1'b0;
                        tol_q  <= 1'b0;
                        nfe_q  <= 1'b0;
                    end else if (wr_ok_w) begin
                        // see [RULE8]
                        if (addr_in == A_MODE) mode_q <= wdata_in[15:0];
                        if (addr_in == A_DATA) data_q <= wdata_in[15:0];
                        if (addr_in == tcfd_pkg::OFF_OUT_ENABLE)
                            toe_q <= wdata_in[g];
                        if (addr_in == tcfd_pkg::OFF_OUT_MODE)
                            tom_q <= wdata_in[g];
                        if (addr_in == tcfd_pkg::OFF_OUT_LEVEL)
                            tol_q <= wdata_in[g];
                        if (addr_in == tcfd_pkg::OFF_FILTER_EN)
                            nfe_q <= wdata_in[g];
                    end
                end

                always_ff @(posedge mclk_in) begin
                    if (rst_in || unit_clr_w) begin
                        en_q   <= 1'b0;
                        pend_q <= 1'b0;
                        cnt_q  <= tcfd_pkg::RST_COUNT;
                    end else if (start_w) begin
                        en_q   <= 1'b1; // see [RULE3]
                        pend_q <= 1'b1;
                    end else if (stop_w) begin
                        en_q   <= 1'b0; // see [RULE10]
                        pend_q <= 1'b0;
                    end else if (en_q && edge_w) begin
                        pend_q <= 1'b0;
                        // New data from next period
                        // see [RULE4] see [RULE6] see [RULE22] see [RULE21]
                        cnt_q  <= (pend_q || zero_w) ? data_q
                                                     : cnt_q - 16'h0001;
                    end
                end

                // see [RULE11]
                always_ff @(posedge mclk_in) begin
                    if (rst_in || unit_clr_w) begin
                        to_q  <= 1'b0;
                        pin_q <= 1'b0;
                        irq_q <= 1'b0;
                    end else begin
                        to_q  <= to_d;
                        // see [RULE16]
                        pin_q <= to_d ^ (tom_q && tol_q);
                        irq_q <= event_w; // see [RULE7] see [RULE23]
                    end
                end

                assign en_vec_w[g]  = en_q;
                assign to_vec_w[g]  = to_q;
                assign toe_vec_w[g] = toe_q;
                assign tom_vec_w[g] = tom_q;
                assign tol_vec_w[g] = tol_q;
                assign nfe_vec_w[g] = nfe_q;
                assign ch_hit_w[g]  = addr_in == A_MODE ||
                                      addr_in == A_DATA ||
                                      addr_in == A_CNT;
                // see [RULE8]
                assign ch_rd_w[g] = (addr_in == A_MODE) ? mode_q :
                                    (addr_in == A_DATA) ? data_q :
                                    (addr_in == A_CNT)  ? cnt_q : 16'h0000;
                assign timer_output_out[g]      = pin_q;
                assign channel_interrupt_out[g] = irq_q;
            end else begin : g_none
                // No divider here
                assign en_vec_w[g]  = 1'b0;
                assign to_vec_w[g]  = 1'b0;
                assign toe_vec_w[g] = 1'b0;
                assign tom_vec_w[g] = 1'b0;
                assign tol_vec_w[g] = 1'b0;
                assign nfe_vec_w[g] = 1'b0;
                assign ch_hit_w[g]  = 1'b0;
                assign ch_rd_w[g]   = 16'h0000;
                assign timer_output_out[g]      = 1'b0;
                assign channel_interrupt_out[g] = 1'b0;
            end
        end
    endgenerate

    // ************************************************************
    // Read data
    // ************************************************************
    logic [15:0] ch_or_w;
    logic [15:0] rd_sel_w;

    always_comb begin
        ch_or_w = 16'h0000;
        for (int i = 0; i < CH_NUM; i++) begin
            ch_or_w = ch_or_w | ch_rd_w[i];
        end
    end

    // see [RULE3] see [RULE10]
    assign rd_sel_w =
        (addr_in == tcfd_pkg::OFF_PRESCALE)    ? {8'h00, prescale_q} :
        (addr_in == tcfd_pkg::OFF_ENABLE_STAT) ? {12'h000, en_vec_w} :
        (addr_in == tcfd_pkg::OFF_TIMER_OUT)   ? {12'h000, to_vec_w} :
        (addr_in == tcfd_pkg::OFF_OUT_ENABLE)  ? {12'h000, toe_vec_w} :
        (addr_in == tcfd_pkg::OFF_OUT_MODE)    ? {12'h000, tom_vec_w} :
        (addr_in == tcfd_pkg::OFF_OUT_LEVEL)   ? {12'h000, tol_vec_w} :
        (addr_in == tcfd_pkg::OFF_FILTER_EN)   ? {12'h000, nfe_vec_w} :
        (|ch_hit_w)                            ? ch_or_w : 16'h0000;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in && addr_in == tcfd_pkg::OFF_UNIT_CTRL) begin
            rdata_out <= {31'h0000_0000, power_q};
        end else if (rd_ok_w) begin
            rdata_out <= {16'h0000, rd_sel_w};
        end else begin
            rdata_out <= 32'h0000_0000; // see [RULE1]
        end
    end

endmodule : tcfd_timer_unit

// file: tcfd_unit_chk.sv
/* Checker bound to the timer unit's top ports.
   Assumes power and enable state follow the bus. */
`timescale 1ns/1ns
module tcfd_unit_chk (
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [3:0]  timer_input_pin_in,
    input wire logic [31:0] rdata_out,
    input wire logic [3:0]  timer_output_out,
    input wire logic [3:0]  channel_interrupt_out
);
    // ************************************************************
    // Port history
    // ************************************************************
    logic       pwr_q;
    logic       oe0_q;
    logic       pin0_q;
    logic [3:0] wr_age_q;
    logic [3:0] pin_age_q;
    wire        hit_ctrl = wr_in && addr_in == tcfd_pkg::OFF_UNIT_CTRL;
    wire        hit_oe = wr_in && pwr_q && addr_in == tcfd_pkg::OFF_OUT_ENABLE;
    wire        pin_chg = timer_input_pin_in[0] != pin0_q;

    // Ages saturate: no wrap
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pwr_q     <= 1'b0;
            oe0_q     <= 1'b0;
            wr_age_q  <= 4'hf;
            pin_age_q <= 4'hf;
        end else begin
            pwr_q     <= hit_ctrl ? wdata_in[0] : pwr_q;
            oe0_q     <= hit_oe ? wdata_in[0] : (pwr_q && oe0_q);
            wr_age_q  <= wr_in ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
            pin_age_q <= pin_chg ? 4'h0
                                 : pin_age_q + {3'h0, pin_age_q != 4'hf};
        end
        pin0_q <= timer_input_pin_in[0];
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence s_off;
        !pwr_q [*4];
    endsequence
    sequence s_trig_rd;
        rd_in && (addr_in == tcfd_pkg::OFF_START_TRIG ||
                  addr_in == tcfd_pkg::OFF_STOP_TRIG);
    endsequence
    a_irq_one_cycle: assert property (
        channel_interrupt_out[0] |=> !channel_interrupt_out[0])
        else $error("irq too long");
    a_irq_after_edge: assert property (
        channel_interrupt_out[0] |-> pin_age_q < 4'ha)
        else $error("irq without pin edge");
    a_irq_toggles: assert property (
        channel_interrupt_out[0] && oe0_q |->
        timer_output_out[0] != $past(timer_output_out[0]))
        else $error("irq without toggle");
    a_out_has_cause: assert property (
        $changed(timer_output_out[0]) |->
        channel_interrupt_out[0] || wr_age_q < 4'h4)
        else $error("output moved without cause");
    a_absent_quiet: assert property (
        timer_output_out[2:1] == 2'b00 && channel_interrupt_out[2:1] == 2'b00)
        else $error("absent channel active");
    a_off_read_zero: assert property (
        rd_in && !pwr_q && addr_in != tcfd_pkg::OFF_UNIT_CTRL |=>
        rdata_out == 32'h0)
        else $error("read answered when off");
    a_off_quiet: assert property (
        s_off |-> timer_output_out == 4'h0 && channel_interrupt_out == 4'h0)
        else $error("outputs active when off");
    a_trig_reads_0: assert property (
        s_trig_rd |=> rdata_out == 32'h0)
        else $error("trigger read nonzero");
    a_rdata_idle: assert property (
        !rd_in |=> rdata_out == 32'h0)
        else $error("stray read data");
endmodule : tcfd_unit_chk

bind tcfd_timer_unit tcfd_unit_chk u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .timer_input_pin_in(timer_input_pin_in), .rdata_out(rdata_out),
    .timer_output_out(timer_output_out),
    .channel_interrupt_out(channel_interrupt_out)
);

// file: tcfd_ext_clk.sv
/* External clock source for the timer input pins.
   Assumes run_in and half_in change while parked. */
`timescale 1ns/1ns
module tcfd_ext_clk (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        run_in,
    input  wire logic [7:0]  half_in,
    output logic             pin_out,
    output logic      [15:0] pulses_out
);
    // ************************************************************
    // Burst generator
    // ************************************************************
    logic [7:0] cnt_q;
    // Parks low between bursts
    always_ff @(posedge mclk_in) begin
        if (rst_in || !run_in) begin
            cnt_q   <= 8'h00;
            pin_out <= 1'b0;
        end else if (cnt_q == half_in - 8'h01) begin
            cnt_q   <= 8'h00;
            pin_out <= !pin_out;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // Counted at the falling half
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pulses_out <= 16'h0000;
        end else if (run_in && pin_out && cnt_q == half_in - 8'h01) begin
            pulses_out <= pulses_out + 16'h0001;
        end
    end
endmodule : tcfd_ext_clk

// file: timer_channel_freq_divider_tb.sv
/* Self-checking bench for the timer unit, channels 0 and 3.
   Assumes the unit's register map and latencies. */
`timescale 1ns/1ns
module timer_channel_freq_divider_tb;
    // ************************************************************
    // Signals and model state
    // ************************************************************
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        rd_seen = 1'b0;
    logic        run_q = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [7:0]  half_q = 8'h03;
    logic [31:0] wdata_in = 32'h0;
    logic [1:0]  junk_q = 2'b00;
    logic        pin;
    logic [15:0] pulses;
    logic [31:0] rdata_out;
    logic [3:0]  tout;
    logic [3:0]  irq;
    logic [31:0] exp_q[$];
    logic        m_md, m_to, m_ld;
    int          miscompares = 0, n_tests = 0, cycles = 0;
    int          n_irq0 = 0, n_irq3 = 0, m_cnt, m_data, m_irq;
    localparam logic [7:0] CH0 = tcfd_pkg::OFF_CH_BASE;
    localparam logic [7:0] CH3 = tcfd_pkg::OFF_CH_BASE + 8'h30;

    always #4 mclk_in = ~mclk_in;

    tcfd_timer_unit u_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .timer_input_pin_in({pin, junk_q, pin}), .rdata_out(rdata_out),
        .timer_output_out(tout), .channel_interrupt_out(irq));
    tcfd_ext_clk u_src (
        .mclk_in(mclk_in), .rst_in(rst_in), .run_in(run_q),
        .half_in(half_q), .pin_out(pin), .pulses_out(pulses));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        junk_q <= 2'($urandom);
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        exp_q.push_back(e);
        @(posedge mclk_in);
        rd_in <= 1'b0;
    endtask : rd
    task automatic wr_both(input logic [7:0] off, input logic [31:0] d);
        wr(CH0 + off, d);
        wr(CH3 + off, d);
    endtask : wr_both
    // live steps the model per valid edge
    task automatic burst(input int n, input logic live);
        int k;
        k = pulses + n;
        for (int j = 0; j < n && live; j++) begin
            if (!m_ld || m_cnt == 0) begin
                if (m_ld || m_md) begin
                    m_irq++;
                    m_to = !m_to;
                end
                m_cnt = m_data;
                m_ld = 1'b1;
            end else begin
                m_cnt--;
            end
        end
        @(posedge mclk_in);
        half_q <= 8'($urandom_range(2, 6));
        run_q <= 1'b1;
        while (pulses != 16'(k)) @(posedge mclk_in);
        run_q <= 1'b0;
        repeat (12) @(posedge mclk_in);
        rd(CH0 + tcfd_pkg::OFF_CH_COUNT, m_cnt);
        chk(n_irq0, m_irq);
        chk(n_irq3, m_irq);
        chk({28'h0, tout}, {28'h0, m_to, 2'b00, m_to});
    endtask : burst

    // ************************************************************
    // Result watcher
    // ************************************************************
    always @(posedge mclk_in) begin
        if (rd_seen) begin
            chk(rdata_out, exp_q.pop_front());
        end
        rd_seen <= rd_in;
        n_irq0 += int'(irq[0]);
        n_irq3 += int'(irq[3]);
        cycles++;
        if (cycles > 40000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(97316));
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        wr(CH0 + tcfd_pkg::OFF_CH_DATA, 32'h5);
        rd(CH0 + tcfd_pkg::OFF_CH_DATA, 32'h0);
        wr(tcfd_pkg::OFF_UNIT_CTRL, 32'h1);
        rd(tcfd_pkg::OFF_UNIT_CTRL, 32'h1);
        rd(CH0 + tcfd_pkg::OFF_CH_COUNT, 32'h0000ffff);
        rd(CH0 + tcfd_pkg::OFF_CH_DATA, 32'h0);
        rd(8'h3c, 32'h0);
        wr(tcfd_pkg::OFF_TIMER_OUT, 32'h9);
        repeat (2) @(posedge mclk_in);
        chk({28'h0, tout}, 32'h9);
        wr(tcfd_pkg::OFF_TIMER_OUT, 32'h0);
        wr(tcfd_pkg::OFF_PRESCALE, 32'h0);
        wr(tcfd_pkg::OFF_FILTER_EN, 32'($urandom_range(0,15)));
        wr(tcfd_pkg::OFF_OUT_MODE, 32'h0);
        wr(tcfd_pkg::OFF_OUT_LEVEL, 32'($urandom_range(0,15)));
        wr(tcfd_pkg::OFF_OUT_ENABLE, 32'h9);
        m_to = 1'b0;
        m_irq = 0;
        for (int it = 0; it < 2; it++) begin
            // Pass 0 rise; pass 1 fall with start event
            m_md = it[0];
            m_data = $urandom_range(1, 4);
            wr_both(tcfd_pkg::OFF_CH_MODE,
                    it ? 32'h1 : 32'h40);
            wr_both(tcfd_pkg::OFF_CH_DATA, m_data);
            wr(tcfd_pkg::OFF_START_TRIG, 32'h9);
            m_ld = 1'b0;
            rd(tcfd_pkg::OFF_START_TRIG, 32'h0);
            rd(tcfd_pkg::OFF_ENABLE_STAT, 32'h9);
            burst(m_data + 2 + it, 1'b1);
            m_data = $urandom_range(0, 5);
            wr_both(tcfd_pkg::OFF_CH_DATA, m_data);
            burst(2 * m_data + 3, 1'b1);
            wr(tcfd_pkg::OFF_STOP_TRIG, 32'h9);
            rd(tcfd_pkg::OFF_STOP_TRIG, 32'h0);
            rd(tcfd_pkg::OFF_ENABLE_STAT, 32'h0);
            burst(3, 1'b0);
        end
        wr(tcfd_pkg::OFF_OUT_ENABLE, 32'h0);
        wr(tcfd_pkg::OFF_TIMER_OUT, 32'h0);
        wr(tcfd_pkg::OFF_UNIT_CTRL, 32'h0);
        wr(tcfd_pkg::OFF_UNIT_CTRL, 32'h1);
        rd(CH0 + tcfd_pkg::OFF_CH_COUNT, 32'h0000ffff);
        rd(CH0 + tcfd_pkg::OFF_CH_MODE, 32'h0);
        rd(tcfd_pkg::OFF_OUT_ENABLE, 32'h0);
        repeat (3) @(posedge mclk_in);
        chk({28'h0, tout}, 32'h0);
        end_of_test();
    end
endmodule : timer_channel_freq_divider_tb
